// >>> logic/uart_ctl_pkg.sv
/*
 * Shared constants for the UART interrupt/FIFO control register bank:
 * register offsets, field positions, reset values, identification codes.
 * Assumes a byte-wide register port with a 4-bit register address.
 */
package uart_ctl_pkg;
	localparam logic [3:0] OFS_DIV_HIGH = 4'h1;
	localparam logic [3:0] OFS_IRQ_EN = 4'h1;
	localparam logic [3:0] OFS_IDENT = 4'h2;
	localparam logic [3:0] OFS_FIFO_CTL = 4'h2;
	localparam logic [3:0] OFS_LINE_CTL = 4'h3;
	localparam logic [7:0] LINE_CTL_ENH = 8'hBF;
	localparam int LINE_CTL_DLAB = 7;
	localparam logic [7:0] LINE_CTL_RESET = 8'h1D;
	localparam logic [7:0] DIV_HIGH_RESET = 8'h00;
	localparam logic [7:0] IRQ_EN_RESET = 8'h00;
	localparam logic [7:0] IDENT_RESET = 8'h01;
	localparam logic [7:0] FIFO_CTL_RESET = 8'h00;
	localparam int IE_CTS = 7;
	localparam int IE_RTS = 6;
	localparam int IE_XOFF = 5;
	localparam int IE_SLEEP = 4;
	localparam int IE_MODEM = 3;
	localparam int IE_LINE = 2;
	localparam int IE_TX = 1;
	localparam int IE_RX = 0;
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_CLR = 1;
	localparam int FC_TX_CLR = 2;
	localparam logic [5:0] ID_LINE = 6'h06;
	localparam logic [5:0] ID_TIMEOUT = 6'h0C;
	localparam logic [5:0] ID_RX = 6'h04;
	localparam logic [5:0] ID_TX = 6'h02;
	localparam logic [5:0] ID_MODEM = 6'h00;
	localparam logic [5:0] ID_PIN = 6'h30;
	localparam logic [5:0] ID_XOFF = 6'h10;
	localparam logic [5:0] ID_CTSRTS = 6'h20;
	localparam logic [5:0] ID_NONE = 6'h01;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [6:0] RX_TRIG_0 = 7'h08;
	localparam logic [6:0] RX_TRIG_1 = 7'h10;
	localparam logic [6:0] RX_TRIG_2 = 7'h38;
	localparam logic [6:0] RX_TRIG_3 = 7'h3C;
	localparam logic [6:0] TX_TRIG_0 = 7'h08;
	localparam logic [6:0] TX_TRIG_1 = 7'h10;
	localparam logic [6:0] TX_TRIG_2 = 7'h20;
	localparam logic [6:0] TX_TRIG_3 = 7'h38;
	localparam logic [6:0] TRIG_ONE = 7'h01;
endpackage : uart_ctl_pkg

// >>> logic/uart_irq_prio.sv
/*
 * Priority encoder for the interrupt identification code.
 * Assumes the pending vector is already gated by the enables.
 */
`timescale 1ns/10ps
module uart_irq_prio
	import uart_ctl_pkg::*;
(
	input wire logic line_err,
	input wire logic rx_timeout,
	input wire logic rx_ready,
	input wire logic tx_ready,
	input wire logic modem,
	input wire logic pin_change,
	input wire logic xoff_char,
	input wire logic cts_rts_off,
	output logic [5:0] code
);
	always_comb begin
		if (line_err)
			code = ID_LINE;
		else if (rx_timeout)
			code = ID_TIMEOUT;
		else if (rx_ready)
			code = ID_RX;
		else if (tx_ready)
			code = ID_TX;
		else if (modem)
			code = ID_MODEM;
		else if (pin_change)
			code = ID_PIN;
		else if (xoff_char)
			code = ID_XOFF;
		else if (cts_rts_off)
			code = ID_CTSRTS;
		else
			code = ID_NONE;
	end
endmodule : uart_irq_prio

// >>> logic/uart_sleep_ctl.sv
/*
 * Sleep state machine: decides when the oscillator may stop and
 * when it must restart. Runs on the always-on register clock.
 */
`timescale 1ns/10ps
module uart_sleep_ctl (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic sleep_allowed,
	input wire logic any_pending,
	input wire logic modem_toggle,
	input wire logic rx_pin,
	input wire logic fifos_empty,
	input wire logic tx_load,
	output logic asleep
);
	typedef enum logic [1:0] {AWAKE = 2'b00, ASLEEP = 2'b01} sleep_e;
	sleep_e state;
	sleep_e next_state;
	logic may_sleep;
	logic wake;
	assign may_sleep = sleep_allowed && !any_pending && !modem_toggle
		&& rx_pin && fifos_empty && !tx_load;
	assign wake = modem_toggle || !rx_pin || tx_load;
	always_comb begin
		case (state)
			AWAKE: next_state = may_sleep ? ASLEEP : AWAKE;
			ASLEEP: next_state = (wake || !sleep_allowed) ? AWAKE : ASLEEP;
			default: next_state = AWAKE;
		endcase
	end
	always_ff @(posedge clk_sys) begin
		if (reset)
			state <= AWAKE;
		else
			state <= next_state;
	end
	// oscillator stop request; the uart clock gate follows this level
	assign asleep = (state == ASLEEP);
	chk_sleep_wake: assert property (@(posedge clk_sys) disable iff (reset)
		asleep && (!rx_pin || tx_load) |=> !asleep)
		else $error("sleep not left on wake event");
	chk_sleep_enter: assert property (@(posedge clk_sys) disable iff (reset)
		$rose(asleep) |-> $past(fifos_empty) && $past(rx_pin))
		else $error("sleep entered with conditions unmet");
	cov_sleep: cover property (@(posedge clk_sys) $rose(asleep));
endmodule : uart_sleep_ctl

// >>> logic/uart_ctl_regs.sv
/*
 * Interrupt enable, divisor high byte, interrupt identification and
 * FIFO control registers of a single UART channel, with sleep control.
 * Assumes a byte register port (address, write/read strobes) from the
 * host-port logic, and status inputs from the serial datapath.
 */
// Notes on behaviour
// - enable bits 7,6,3,2,0 gate cts, rts, modem, line and rx sources
// - enable bit 5 gates the xoff/special character interrupt
// - enable bit 1 gates tx ready: holding empty or space above trigger
// - enable bits 7:4 written only while enhanced enable is set
// - sleep only with no pending irq, stable modem, rx high, fifos empty
// - wake on modem toggle, rx going low, or transmit fifo load
// - while asleep the oscillator is stopped
// - divisor high at offset 1 when dlab set and not 0xBF; power-on only
// - ident priorities 1 to 3: line, timeout/rx data, tx ready
// - ident priorities 4 to 7: modem, pin, xoff, cts/rts off
// - fifo control 7:6 picks rx trigger 8, 16, 56 or 60
// - fifo control bit 1 clears rx fifo, self-clearing pulse
// - tx trigger field writable and effective only with enhanced enable
// - fifo enable low: one-char fifos, trigger one, bits 7:4 locked, clear bits 2:1 still act
`timescale 1ns/10ps
module uart_ctl_regs
	import uart_ctl_pkg::*;
#(
	parameter int FIFO_BITS = 7
) (
	input wire logic clk_sys,
	input wire logic reset,
	input wire logic power_on_reset,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic [7:0] line_control,
	input wire logic enhanced_enable,
	input wire logic [FIFO_BITS-1:0] rx_level,
	input wire logic [FIFO_BITS-1:0] tx_level,
	input wire logic line_err,
	input wire logic rx_timeout,
	input wire logic modem_change,
	input wire logic pin_change,
	input wire logic xoff_char,
	input wire logic cts_rts_off,
	input wire logic cts_dsr_change,
	input wire logic rts_dtr_change,
	input wire logic modem_toggle,
	input wire logic rx_pin,
	input wire logic tx_load,
	output logic [7:0] divisor_high_byte,
	output logic [FIFO_BITS-1:0] rx_trigger,
	output logic [FIFO_BITS-1:0] tx_trigger,
	output logic [FIFO_BITS-1:0] fifo_depth,
	output logic fifo_enable,
	output logic rx_fifo_clear,
	output logic tx_fifo_clear,
	output logic irq_pending,
	output logic osc_stop
);
	logic [7:0] interrupt_enable;
	logic [7:0] fifo_control;
	logic [7:0] interrupt_ident;
	logic [5:0] ident_code;
	logic dlab;
	logic enh_map;
	logic sel_div_high;
	logic sel_irq_en;
	logic sel_fifo;
	logic wr_div_high;
	logic wr_irq_en;
	logic wr_fifo;
	logic [7:0] next_irq_en;
	logic [7:0] next_fifo_ctl;
	logic rx_ready;
	logic tx_ready;
	logic [FIFO_BITS-1:0] tx_space;
	logic en_line;
	logic en_rx;
	logic en_tx;
	logic en_modem;
	logic en_xoff;
	logic en_pin;
	logic en_ctsrts;

	// address decode
	assign dlab = line_control[LINE_CTL_DLAB];
	assign enh_map = (line_control == LINE_CTL_ENH);
	assign sel_div_high = (reg_addr == OFS_DIV_HIGH) && dlab && !enh_map;
	assign sel_irq_en = (reg_addr == OFS_IRQ_EN) && !dlab;
	assign sel_fifo = (reg_addr == OFS_FIFO_CTL) && !dlab;
	assign wr_div_high = reg_write && sel_div_high;
	assign wr_irq_en = reg_write && sel_irq_en;
	assign wr_fifo = reg_write && sel_fifo;

	// upper enable bits hold unless the enhanced functions are on
	assign next_irq_en = enhanced_enable ? reg_wdata
		: {interrupt_enable[7:4], reg_wdata[3:0]};

	always_comb begin
		next_fifo_ctl = fifo_control;
		next_fifo_ctl[FC_ENABLE] = reg_wdata[FC_ENABLE];
		if (reg_wdata[FC_ENABLE]) begin
			next_fifo_ctl[7:6] = reg_wdata[7:6];
			if (enhanced_enable)
				next_fifo_ctl[5:4] = reg_wdata[5:4];
		end
		// clear bits are never stored; they act as a one-cycle pulse
		next_fifo_ctl[3:1] = 3'b000;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			interrupt_enable <= IRQ_EN_RESET;
			fifo_control <= FIFO_CTL_RESET;
		end else begin
			if (wr_irq_en)
				interrupt_enable <= next_irq_en;
			if (wr_fifo)
				fifo_control <= next_fifo_ctl;
		end
	end

	// divisor high byte survives soft reset, only power-on clears it
	always_ff @(posedge clk_sys) begin
		if (power_on_reset)
			divisor_high_byte <= DIV_HIGH_RESET;
		else if (wr_div_high)
			divisor_high_byte <= reg_wdata;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rx_fifo_clear <= 1'b0;
			tx_fifo_clear <= 1'b0;
		end else begin
			rx_fifo_clear <= wr_fifo && reg_wdata[FC_RX_CLR];
			tx_fifo_clear <= wr_fifo && reg_wdata[FC_TX_CLR];
		end
	end

	assign fifo_enable = fifo_control[FC_ENABLE];
	assign fifo_depth = fifo_enable ? FIFO_BITS'(FIFO_DEPTH)
		: FIFO_BITS'(TRIG_ONE);

	always_comb begin
		case (fifo_control[7:6])
			2'b00: rx_trigger = FIFO_BITS'(RX_TRIG_0);
			2'b01: rx_trigger = FIFO_BITS'(RX_TRIG_1);
			2'b10: rx_trigger = FIFO_BITS'(RX_TRIG_2);
			2'b11: rx_trigger = FIFO_BITS'(RX_TRIG_3);
			default: rx_trigger = FIFO_BITS'(RX_TRIG_0);
		endcase
		if (!fifo_enable)
			rx_trigger = FIFO_BITS'(TRIG_ONE);
	end

	always_comb begin
		case (fifo_control[5:4])
			2'b00: tx_trigger = FIFO_BITS'(TX_TRIG_0);
			2'b01: tx_trigger = FIFO_BITS'(TX_TRIG_1);
			2'b10: tx_trigger = FIFO_BITS'(TX_TRIG_2);
			2'b11: tx_trigger = FIFO_BITS'(TX_TRIG_3);
			default: tx_trigger = FIFO_BITS'(TX_TRIG_0);
		endcase
		if (!enhanced_enable)
			tx_trigger = FIFO_BITS'(TX_TRIG_0);
		if (!fifo_enable)
			tx_trigger = FIFO_BITS'(TRIG_ONE);
	end

	// interrupt sources
	assign tx_space = fifo_depth - tx_level;
	assign rx_ready = (rx_level >= rx_trigger);
	assign tx_ready = fifo_enable ? (tx_space > tx_trigger)
		: (tx_level == '0);
	assign en_line = interrupt_enable[IE_LINE] && line_err;
	assign en_rx = interrupt_enable[IE_RX] && rx_ready;
	assign en_tx = interrupt_enable[IE_TX] && tx_ready;
	assign en_modem = interrupt_enable[IE_MODEM] && modem_change;
	assign en_xoff = interrupt_enable[IE_XOFF] && xoff_char;
	assign en_pin = (interrupt_enable[IE_CTS] && cts_dsr_change)
		|| (interrupt_enable[IE_RTS] && rts_dtr_change);
	assign en_ctsrts = (interrupt_enable[IE_CTS] || interrupt_enable[IE_RTS])
		&& cts_rts_off;

	uart_irq_prio u_prio (
		.line_err(en_line),
		.rx_timeout(interrupt_enable[IE_RX] && rx_timeout),
		.rx_ready(en_rx),
		.tx_ready(en_tx),
		.modem(en_modem),
		.pin_change(en_pin && pin_change),
		.xoff_char(en_xoff),
		.cts_rts_off(en_ctsrts),
		.code(ident_code)
	);

	// bit 0 low means pending, so the idle code reads 01
	assign irq_pending = (ident_code != ID_NONE);
	assign interrupt_ident = {{2{fifo_enable}}, ident_code};

	uart_sleep_ctl u_sleep (
		.clk_sys(clk_sys),
		.reset(reset),
		.sleep_allowed(interrupt_enable[IE_SLEEP] && enhanced_enable),
		.any_pending(irq_pending),
		.modem_toggle(modem_toggle),
		.rx_pin(rx_pin),
		.fifos_empty((rx_level == '0) && (tx_level == '0)),
		.tx_load(tx_load),
		.asleep(osc_stop)
	);

	// read data registered; unmapped offsets read zero
	always_ff @(posedge clk_sys) begin
		if (reset)
			reg_rdata <= 8'h00;
		else if (reg_read && sel_div_high)
			reg_rdata <= divisor_high_byte;
		else if (reg_read && sel_irq_en)
			reg_rdata <= interrupt_enable;
		else if (reg_read && sel_fifo)
			reg_rdata <= interrupt_ident;
		else if (reg_read)
			reg_rdata <= 8'h00;
	end

	chk_upper_en_lock: assert property (@(posedge clk_sys) disable iff (reset)
		wr_irq_en && !enhanced_enable
		|=> interrupt_enable[7:4] == $past(interrupt_enable[7:4]))
		else $error("upper enable bits changed without enhanced enable");
	chk_rx_clr_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		wr_fifo && reg_wdata[FC_RX_CLR] |=> rx_fifo_clear ##1 !rx_fifo_clear
		)
		else $error("rx clear not a single pulse");
	chk_tx_clr_pulse: assert property (@(posedge clk_sys) disable iff (reset)
		wr_fifo && reg_wdata[FC_TX_CLR] |=> tx_fifo_clear ##1 !tx_fifo_clear
		)
		else $error("tx clear not a single pulse");
	chk_div_write: assert property (@(posedge clk_sys)
		disable iff (power_on_reset)
		wr_div_high |=> divisor_high_byte == $past(reg_wdata))
		else $error("divisor high byte not written");
	chk_div_lock: assert property (@(posedge clk_sys)
		disable iff (power_on_reset)
		!wr_div_high && !power_on_reset |=> $stable(divisor_high_byte))
		else $error("divisor high byte changed without write");
	chk_line_first: assert property (@(posedge clk_sys) disable iff (reset)
		en_line |-> ident_code == ID_LINE)
		else $error("line status not highest priority");
	chk_idle_code: assert property (@(posedge clk_sys) disable iff (reset)
		!(en_line || en_rx || en_tx || en_modem || en_xoff || en_ctsrts
		|| (en_pin && pin_change) || (interrupt_enable[IE_RX] && rx_timeout))
		|-> interrupt_ident[0])
		else $error("pending shown with no source");
	chk_rx_trig: assert property (@(posedge clk_sys) disable iff (reset)
		fifo_enable && fifo_control[7:6] == 2'b11
		|-> rx_trigger == FIFO_BITS'(RX_TRIG_3))
		else $error("rx trigger 60 not applied");
	chk_tx_trig: assert property (@(posedge clk_sys) disable iff (reset)
		fifo_enable && enhanced_enable && fifo_control[5:4] == 2'b10
		|-> tx_trigger == FIFO_BITS'(TX_TRIG_2))
		else $error("tx trigger 32 not applied");
	chk_no_fifo: assert property (@(posedge clk_sys) disable iff (reset)
		!fifo_enable |-> rx_trigger == FIFO_BITS'(TRIG_ONE))
		else $error("trigger not one with fifos off");
	cov_rx_clear: cover property (@(posedge clk_sys) rx_fifo_clear);
	cov_tx_irq: cover property (@(posedge clk_sys) ident_code == ID_TX);
	cov_en_write: cover property (@(posedge clk_sys)
		wr_irq_en && enhanced_enable);
endmodule : uart_ctl_regs

// >>> dv/uart_host_model.sv
/*
 * Host side of the register port: byte writes and reads by task.
 * Assumes one clock; strobes are taken at the rising edge of clk_sys.
 */
`timescale 1ns/10ps
module uart_host_model (
	input wire logic clk_sys,
	output logic [3:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_write,
	output logic reg_read,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 4'h0;
		reg_wdata = 8'h00;
		reg_write = 1'b0;
		reg_read = 1'b0;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk_sys);
		reg_write <= 1'b0;
		// stale data must not look like a held value
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk_sys);
		reg_read <= 1'b0;
		#1;
		d = reg_rdata;
	endtask : rd
endmodule : uart_host_model

// >>> dv/uart_interrupt_fifo_control_test.sv
/*
 * Self-checking bench for the UART control register bank.
 * Assumes the host model drives the register port; status is driven here.
 */
`timescale 1ns/10ps
module uart_interrupt_fifo_control_test;
	import uart_ctl_pkg::*;
	logic clk_sys, reset, power_on_reset, reg_write, reg_read;
	logic [3:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, line_control, divisor_high_byte;
	logic [6:0] rx_level, tx_level, rx_trigger, tx_trigger, fifo_depth;
	logic enhanced_enable, line_err, rx_timeout, modem_change, pin_change;
	logic xoff_char, cts_rts_off, modem_toggle, rx_pin, tx_load;
	logic cts_dsr_change, rts_dtr_change;
	logic fifo_enable, rx_fifo_clear, tx_fifo_clear, irq_pending, osc_stop;
	logic [7:0] d, v, ie, fc;
	logic [6:0] rx_tab [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
	logic [6:0] tx_tab [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
	int mismatches = 0;
	int n_tests = 0;

	uart_host_model i_uart_host_model (.clk_sys(clk_sys),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata));
	// pin-change qualifiers are drawn apart so bits 7 and 6 gate separately
	uart_ctl_regs #(.FIFO_BITS(7)) i_uart_ctl_regs (.clk_sys(clk_sys),
		.reset(reset), .power_on_reset(power_on_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata),
		.line_control(line_control), .enhanced_enable(enhanced_enable),
		.rx_level(rx_level), .tx_level(tx_level), .line_err(line_err),
		.rx_timeout(rx_timeout), .modem_change(modem_change),
		.pin_change(pin_change), .xoff_char(xoff_char),
		.cts_rts_off(cts_rts_off), .cts_dsr_change(cts_dsr_change),
		.rts_dtr_change(rts_dtr_change), .modem_toggle(modem_toggle),
		.rx_pin(rx_pin), .tx_load(tx_load),
		.divisor_high_byte(divisor_high_byte), .rx_trigger(rx_trigger),
		.tx_trigger(tx_trigger), .fifo_depth(fifo_depth),
		.fifo_enable(fifo_enable), .rx_fifo_clear(rx_fifo_clear),
		.tx_fifo_clear(tx_fifo_clear), .irq_pending(irq_pending),
		.osc_stop(osc_stop));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic wr(input logic [3:0] a, input logic [7:0] x);
		i_uart_host_model.wr(a, x);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		i_uart_host_model.rd(a, d);
	endtask : rd
	task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_val
	task automatic chk_flag(input logic got, input logic exp);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : chk_flag
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : conclude

	// assumes fifo mode and enhanced enable, triggers from the last fc write
	function automatic logic [5:0] exp_code(input logic [7:0] e);
		logic rxr, txr;
		rxr = rx_level >= rx_tab[fc[7:6]];
		txr = (7'h40 - tx_level) > tx_tab[fc[5:4]];
		if (e[2] && line_err) return 6'h06;
		if (e[0] && rx_timeout) return 6'h0C;
		if (e[0] && rxr) return 6'h04;
		if (e[1] && txr) return 6'h02;
		if (e[3] && modem_change) return 6'h00;
		if (((e[7] && cts_dsr_change) || (e[6] && rts_dtr_change))
			&& pin_change) return 6'h30;
		if (e[5] && xoff_char) return 6'h10;
		if ((e[7] || e[6]) && cts_rts_off) return 6'h20;
		return 6'h01;
	endfunction : exp_code

	initial begin
		#50000;
		mismatches++;
		conclude();
	end

	initial begin
		reset = 1'b1;
		power_on_reset = 1'b1;
		line_control = 8'h00;
		enhanced_enable = 1'b0;
		{rx_level, tx_level} = 14'h0000;
		{line_err, rx_timeout, modem_change, pin_change} = 4'h0;
		{xoff_char, cts_rts_off, modem_toggle, tx_load} = 4'h0;
		{cts_dsr_change, rts_dtr_change} = 2'b00;
		rx_pin = 1'b1;
		void'($urandom(4189));
		repeat (20) @(posedge clk_sys);
		reset <= 1'b0;
		power_on_reset <= 1'b0;
		rd(4'h1);
		chk_val(d, 8'h00);
		rd(4'h2);
		chk_val(d, 8'h01);
		chk_val({1'b0, rx_trigger}, 8'h01);
		rd(4'hE);
		chk_val(d, 8'h00);
		$display("test reset done");

		@(posedge clk_sys);
		line_control <= 8'h80;
		v = 8'($urandom) | 8'h01;
		wr(4'h1, v);
		rd(4'h1);
		chk_val(d, v);
		@(posedge clk_sys);
		line_control <= 8'hBF;
		wr(4'h1, ~v);
		#1 chk_val(divisor_high_byte, v);
		@(posedge clk_sys);
		reset <= 1'b1;
		@(posedge clk_sys);
		reset <= 1'b0;
		#1 chk_val(divisor_high_byte, v);
		@(posedge clk_sys);
		power_on_reset <= 1'b1;
		line_control <= 8'h00;
		@(posedge clk_sys);
		power_on_reset <= 1'b0;
		#1 chk_val(divisor_high_byte, 8'h00);
		$display("test divisor done");

		wr(4'h1, 8'hFF);
		rd(4'h1);
		chk_val(d, 8'h0F);
		enhanced_enable <= 1'b1;
		wr(4'h1, 8'hA5);
		rd(4'h1);
		chk_val(d, 8'hA5);
		enhanced_enable <= 1'b0;
		wr(4'h1, 8'h00);
		rd(4'h1);
		chk_val(d, 8'hA0);
		$display("test enable lock done");

		enhanced_enable <= 1'b1;
		wr(4'h2, 8'hF7);
		#1 chk_flag(rx_fifo_clear, 1'b1);
		chk_flag(tx_fifo_clear, 1'b1);
		chk_val({1'b0, fifo_depth}, 8'h40);
		chk_flag(fifo_enable, 1'b1);
		chk_val({1'b0, tx_trigger}, 8'h38);
		@(posedge clk_sys);
		#1 chk_flag(rx_fifo_clear, 1'b0);
		chk_flag(tx_fifo_clear, 1'b0);
		enhanced_enable <= 1'b0;
		wr(4'h2, 8'h61);
		#1 chk_val({1'b0, tx_trigger}, 8'h08);
		chk_val({1'b0, rx_trigger}, 8'h10);
		@(posedge clk_sys);
		enhanced_enable <= 1'b1;
		#1 chk_val({1'b0, tx_trigger}, 8'h38);
		wr(4'h2, 8'h00);
		#1 chk_val({1'b0, rx_trigger}, 8'h01);
		chk_val({1'b0, fifo_depth}, 8'h01);
		chk_flag(fifo_enable, 1'b0);
		rd(4'h2);
		chk_val(d, 8'h01);
		// non-fifo mode: an empty holding register raises tx ready
		wr(4'h1, 8'h02);
		rd(4'h2);
		chk_val(d, 8'h02);
		$display("test fifo control done");

		for (int i = 0; i < 40; i++) begin
			fc = {i[1:0], i[3:2], 4'h1};
			ie = 8'($urandom) & 8'hEF;
			wr(4'h2, fc);
			wr(4'h1, ie);
			@(posedge clk_sys);
			{line_err, rx_timeout, modem_change} <= 3'($urandom);
			{pin_change, xoff_char, cts_rts_off} <= 3'($urandom);
			{cts_dsr_change, rts_dtr_change} <= 2'($urandom);
			rx_level <= 7'($urandom_range(63));
			tx_level <= 7'($urandom_range(64));
			rd(4'h2);
			chk_val(d, {2'b11, exp_code(ie)});
			chk_flag(irq_pending, exp_code(ie) != 6'h01);
			chk_val({1'b0, rx_trigger}, {1'b0, rx_tab[fc[7:6]]});
			chk_val({1'b0, tx_trigger}, {1'b0, tx_tab[fc[5:4]]});
		end
		$display("test ident done");

		@(posedge clk_sys);
		{line_err, rx_timeout, modem_change, pin_change} <= 4'h8;
		{xoff_char, cts_rts_off, rx_level, tx_level} <= 16'h0000;
		wr(4'h1, 8'h14);
		repeat (3) @(posedge clk_sys);
		#1 chk_flag(osc_stop, 1'b0);
		wr(4'h1, 8'h10);
		repeat (3) @(posedge clk_sys);
		#1 chk_flag(osc_stop, 1'b1);
		for (int k = 0; k < 3; k++) begin
			@(posedge clk_sys);
			rx_pin <= (k != 0);
			modem_toggle <= (k == 1);
			tx_load <= (k == 2);
			@(posedge clk_sys);
			rx_pin <= 1'b1;
			modem_toggle <= 1'b0;
			tx_load <= 1'b0;
			#1 chk_flag(osc_stop, 1'b0);
			repeat (3) @(posedge clk_sys);
			#1 chk_flag(osc_stop, 1'b1);
		end
		$display("test sleep done");
		conclude();
	end
endmodule : uart_interrupt_fifo_control_test
